// ==== design/interrupt_priority_flags.sv ====
`timescale 1ns/1ps
`include "irq_consts.svh"

// Behaviour
// - Sources form six groups, each set by software to one of four levels.
// - Groups 0 to 2: pin A, radio ready; timer 0, radio; pin B, SPI.
// - Groups 3 to 5: timer 1, USB resume; serial, USB; timer 2, wakeup.
// - Low level bits at 0xa9 reset to zero, bit n for group n, 7:6 unused.
// - High level bits at 0xb9 reset to zero, bit n for group n, 7:6 unused.
// - A group level is high bit over low bit, 0 lowest and 3 highest.
// - The request flags at 0xc0 reset to zero and hold the eight listed events.
// - Vectoring clears flags 5 to 1; software alone clears 7, 6 and 0.
// - A running routine is preempted only by a strictly higher level.
// - Master and slave SPI done share a flag and vector, enables 1 and 0.
module interrupt_priority_flags
   import irq_pkg::*;
(
   // Clock and reset.
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_in,
   // Register port.
   input  reg_req_t                   reg_req_in,
   output logic [7:0]                 rd_data_out,
   // External pins, active low.
   input  wire logic                  ext_pin_a_request_n_in,
   input  wire logic                  ext_pin_b_request_n_in,
   // Peripheral requests on this clock.
   input  src_level_t                 src_level_in,
   input  flag_event_t                flag_event_in,
   // Per-slot enables from the core's enable registers.
   input  wire logic [`NUM_SLOTS-1:0] slot_enable_in,
   // Vectoring handshake with the core.
   output irq_offer_t                 offer_out,
   input  wire logic                  vector_ack_in,
   input  wire logic                  return_in,
   // Service state.
   output logic [`NUM_LEVELS-1:0]     in_service_out
);

   ctrl_state_t                q;
   ctrl_state_t                d;
   logic [`NUM_PINS-1:0]       pin_raw;
   logic [`NUM_PINS-1:0]       pin_level;
   logic [`NUM_SLOTS-1:0]      pending;
   irq_offer_t                 winner;
   logic [7:0]                 flag_set;
   logic [7:0]                 flag_clr;
   logic                       ack_ok;

   // Maps a slot to the request-flag bit that it clears when vectored.
   function automatic logic [7:0] autoclr_bits(input logic [3:0] slot);
      logic [7:0] b;
      b = 8'h00;
      case (slot)
         `SLOT_WAKE:        b[`FLAG_WAKE]       = 1'b1;
         `SLOT_USB:         b[`FLAG_USB]        = 1'b1;
         `SLOT_USB_RESUME:  b[`FLAG_USB_RESUME] = 1'b1;
         `SLOT_SPI:         b[`FLAG_SPI]        = 1'b1;
         `SLOT_RADIO:       b[`FLAG_RADIO]      = 1'b1;
         default:           b                   = 8'h00;
      endcase
      autoclr_bits = b & `FLAG_AUTOCLR_MASK;
   endfunction

   // Highest level now in service, valid when any bit is set.
   function automatic logic [1:0] top_level(input logic [3:0] is);
      logic [1:0] t;
      t = 2'h0;
      for (int i = 0; i < `NUM_LEVELS; i++) begin
         if (is[i]) begin
            t = 2'(i);
         end
      end
      top_level = t;
   endfunction

   assign pin_raw = {ext_pin_b_request_n_in, ext_pin_a_request_n_in};

   generate
      for (genvar p = 0; p < `NUM_PINS; p++) begin : g_pin
         irq_pin_sync u_sync (
            .ref_clk_in (ref_clk_in),
            .rst_in     (rst_in),
            .pin_in     (pin_raw[p]),
            .level_out  (pin_level[p])
         );
      end
   endgenerate

   always_comb begin
      flag_set                   = 8'h00;
      flag_set[`FLAG_T2_EXT]     = flag_event_in.tmr2_ext;
      flag_set[`FLAG_T2_OVF]     = flag_event_in.tmr2_ovf;
      flag_set[`FLAG_WAKE]       = flag_event_in.wake;
      flag_set[`FLAG_USB]        = flag_event_in.usb;
      flag_set[`FLAG_USB_RESUME] = flag_event_in.usb_resume;
      flag_set[`FLAG_SPI]        =
         (flag_event_in.master_spi_done & q.spi_ext[`SPI_EXT_MASTER]) |
         (flag_event_in.slave_spi_done & q.spi_ext[`SPI_EXT_SLAVE]);
      flag_set[`FLAG_RADIO]      = flag_event_in.radio;
      flag_set[`FLAG_RADIO_RDY]  = flag_event_in.radio_spi_ready;
   end

   always_comb begin
      pending                   = '0;
      pending[`SLOT_PIN_A]      = ~pin_level[0];
      pending[`SLOT_RADIO_RDY]  = q.flags[`FLAG_RADIO_RDY];
      pending[`SLOT_TMR0]       = src_level_in.tmr0;
      pending[`SLOT_RADIO]      = q.flags[`FLAG_RADIO];
      pending[`SLOT_PIN_B]      = ~pin_level[1];
      pending[`SLOT_SPI]        = q.flags[`FLAG_SPI];
      pending[`SLOT_TMR1]       = src_level_in.tmr1;
      pending[`SLOT_USB_RESUME] = q.flags[`FLAG_USB_RESUME];
      pending[`SLOT_SER_RX]     = src_level_in.ser_rx;
      pending[`SLOT_SER_TX]     = src_level_in.ser_tx;
      pending[`SLOT_USB]        = q.flags[`FLAG_USB];
      pending[`SLOT_T2_OVF]     = q.flags[`FLAG_T2_OVF];
      pending[`SLOT_T2_EXT]     = q.flags[`FLAG_T2_EXT];
      pending[`SLOT_WAKE]       = q.flags[`FLAG_WAKE];
      pending                   = pending & slot_enable_in;
   end

   irq_level_arbiter u_arb (
      .pending_in (pending),
      .prio_lo_in (q.prio_lo),
      .prio_hi_in (q.prio_hi),
      .winner_out (winner)
   );

   // An acknowledge counts only against a request that is being offered.
   assign ack_ok   = vector_ack_in & q.offer.req;

   assign flag_clr = ack_ok ? autoclr_bits(q.offer.slot) : 8'h00;

   always_comb begin
      d       = q;
      d.rdata = 8'h00;

      // Register writes.
      if (reg_req_in.wr) begin
         case (reg_req_in.addr)
            `ADDR_PRIO_LO: d.prio_lo = reg_req_in.wdata[5:0];
            `ADDR_PRIO_HI: d.prio_hi = reg_req_in.wdata[5:0];
            `ADDR_SPI_EXT: d.spi_ext = reg_req_in.wdata[1:0];
            default:       d.prio_lo = q.prio_lo;
         endcase
      end

      if (reg_req_in.wr && reg_req_in.addr == `ADDR_REQ_FLAGS) begin
         d.flags = reg_req_in.wdata;
      end
      // Hardware events win over any clear in the same cycle.
      d.flags = (d.flags & ~flag_clr) | flag_set;

      // Register reads, data in the following cycle.
      if (reg_req_in.rd) begin
         case (reg_req_in.addr)
            `ADDR_PRIO_LO:    d.rdata = {2'h0, q.prio_lo};
            `ADDR_PRIO_HI:    d.rdata = {2'h0, q.prio_hi};
            `ADDR_REQ_FLAGS:  d.rdata = q.flags;
            `ADDR_SPI_EXT:    d.rdata = {6'h00, q.spi_ext};
            `ADDR_IRQ_STATUS: d.rdata = {q.offer.level, q.offer.req,
                                         1'b0, q.in_service};
            default:          d.rdata = 8'h00;
         endcase
      end

      // Return retires the highest level in service, then a vector enters.
      if (return_in && (q.in_service != '0)) begin
         d.in_service[top_level(q.in_service)] = 1'b0;
      end
      if (ack_ok) begin
         d.in_service[q.offer.level] = 1'b1;
      end

      d.offer = '0;
      if (winner.req && !ack_ok && !return_in &&
          ((q.in_service == '0) ||
           (winner.level > top_level(q.in_service)))) begin
         d.offer = winner;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         q.prio_lo    <= `RST_PRIO;
         q.prio_hi    <= `RST_PRIO;
         q.flags      <= `RST_FLAGS;
         q.spi_ext    <= `RST_SPI_EXT;
         q.in_service <= '0;
         q.offer      <= '0;
         q.rdata      <= 8'h00;
      end else begin
         q <= d;
      end
   end

   assign rd_data_out    = q.rdata;
   assign offer_out      = q.offer;
   assign in_service_out = q.in_service;

endmodule

// ==== design/irq_consts.svh ====
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// Register addresses.
`define ADDR_SPI_EXT      8'ha6
`define ADDR_PRIO_LO      8'ha9
`define ADDR_PRIO_HI      8'hb9
`define ADDR_REQ_FLAGS    8'hc0
`define ADDR_IRQ_STATUS   8'hc1

// Reset values.
`define RST_SPI_EXT       2'h1
`define RST_PRIO          6'h00
`define RST_FLAGS         8'h00
`define RST_SYNC          1'h1

// Request-flag bit positions.
`define FLAG_T2_EXT       7
`define FLAG_T2_OVF       6
`define FLAG_WAKE         5
`define FLAG_USB          4
`define FLAG_USB_RESUME   3
`define FLAG_SPI          2
`define FLAG_RADIO        1
`define FLAG_RADIO_RDY    0
`define FLAG_AUTOCLR_MASK 8'h3e

// Extension enable bits.
`define SPI_EXT_MASTER    1
`define SPI_EXT_SLAVE     0

// Field widths.
`define NUM_GROUPS        6
`define NUM_SLOTS         15
`define NUM_LEVELS        4
`define NUM_PINS          2

// Request slots in fixed arbitration order.
`define SLOT_PIN_A        4'h0
`define SLOT_RADIO_RDY    4'h1
`define SLOT_TMR0         4'h2
`define SLOT_RADIO        4'h3
`define SLOT_PIN_B        4'h4
`define SLOT_SPI          4'h5
`define SLOT_TMR1         4'h6
`define SLOT_USB_RESUME   4'h7
`define SLOT_SER_RX       4'h8
`define SLOT_SER_TX       4'h9
`define SLOT_USB          4'ha
`define SLOT_T2_OVF       4'hb
`define SLOT_T2_EXT       4'hc
`define SLOT_WAKE         4'hd

`endif

// ==== design/irq_level_arbiter.sv ====
`timescale 1ns/1ps
`include "irq_consts.svh"

module irq_level_arbiter
   import irq_pkg::*;
(
   // Pending enabled slots and group levels.
   input  wire logic [`NUM_SLOTS-1:0]  pending_in,
   input  wire logic [`NUM_GROUPS-1:0] prio_lo_in,
   input  wire logic [`NUM_GROUPS-1:0] prio_hi_in,
   // Winning request.
   output irq_offer_t                  winner_out
);

   function automatic logic [2:0] slot_group(input logic [3:0] slot);
      case (slot)
         `SLOT_PIN_A, `SLOT_RADIO_RDY:           slot_group = 3'h0;
         `SLOT_TMR0, `SLOT_RADIO:                slot_group = 3'h1;
         `SLOT_PIN_B, `SLOT_SPI:                 slot_group = 3'h2;
         `SLOT_TMR1, `SLOT_USB_RESUME:           slot_group = 3'h3;
         `SLOT_SER_RX, `SLOT_SER_TX, `SLOT_USB:  slot_group = 3'h4;
         default:                                slot_group = 3'h5;
      endcase
   endfunction

   function automatic logic [1:0] slot_level(input logic [3:0] slot);
      logic [2:0] g;
      g          = slot_group(slot);
      slot_level = {prio_hi_in[g], prio_lo_in[g]};
   endfunction

   always_comb begin
      winner_out = '0;
      for (int i = 0; i < `NUM_SLOTS; i++) begin
         if (pending_in[i] && (!winner_out.req ||
             slot_level(4'(i)) > winner_out.level)) begin
            winner_out.req   = 1'b1;
            winner_out.slot  = 4'(i);
            winner_out.level = slot_level(4'(i));
         end
      end
   end

endmodule

// ==== design/irq_pin_sync.sv ====
`timescale 1ns/1ps
`include "irq_consts.svh"

module irq_pin_sync
   import irq_pkg::*;
(
   // Clock and reset.
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   // Asynchronous pin and its filtered level.
   input  wire logic pin_in,
   output logic      level_out
);

   sync_state_t state_q;
   sync_state_t state_d;

   // The output follows only once the second and third stages agree.
   always_comb begin
      state_d    = state_q;
      state_d.s1 = pin_in;
      state_d.s2 = state_q.s1;
      state_d.s3 = state_q.s2;
      if (state_q.s2 == state_q.s3) begin
         state_d.level = state_q.s3;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_q <= {4{`RST_SYNC}};
      end else begin
         state_q <= state_d;
      end
   end

   assign level_out = state_q.level;

endmodule

// ==== design/irq_pkg.sv ====
package irq_pkg;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic tmr0;
      logic tmr1;
      logic ser_rx;
      logic ser_tx;
   } src_level_t;

   typedef struct packed {
      logic tmr2_ext;
      logic tmr2_ovf;
      logic wake;
      logic usb;
      logic usb_resume;
      logic master_spi_done;
      logic slave_spi_done;
      logic radio;
      logic radio_spi_ready;
   } flag_event_t;

   typedef struct packed {
      logic       req;
      logic [3:0] slot;
      logic [1:0] level;
   } irq_offer_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } sync_state_t;

   typedef struct packed {
      logic [5:0] prio_lo;
      logic [5:0] prio_hi;
      logic [7:0] flags;
      logic [1:0] spi_ext;
      logic [3:0] in_service;
      irq_offer_t offer;
      logic [7:0] rdata;
   } ctrl_state_t;

endpackage

// ==== tb/irq_core_model.sv ====
`timescale 1ns/1ps

module irq_core_model
   import irq_pkg::*;
(
   // Clock and reset.
   input wire logic       ref_clk_in,
   input wire logic       rst_in,
   // Offer and service state from the controller.
   input irq_offer_t      offer_in,
   input wire logic [3:0] in_service_in,
   // Test controls: stall vectoring, hold routines open.
   input wire logic       stall_in,
   input wire logic       hold_in,
   // Handshake back to the controller.
   output logic           vector_ack_out,
   output logic           return_out
);
   logic [1:0] wait_q;
   logic       slow_q;

   // Vectoring alternates between prompt and two-cycle latency.
   always_ff @(posedge ref_clk_in) begin
      vector_ack_out <= 1'b0;
      return_out <= 1'b0;
      if (rst_in) begin
         wait_q <= 2'h0;
         slow_q <= 1'b0;
      end else if (offer_in.req && !stall_in && !vector_ack_out) begin
         wait_q <= wait_q + 2'h1;
         if (wait_q >= {slow_q, 1'b0}) begin
            vector_ack_out <= 1'b1;
            wait_q <= 2'h0;
            slow_q <= ~slow_q;
         end
      end else if (!offer_in.req && in_service_in != 4'h0 && !hold_in &&
                   !vector_ack_out && !return_out) begin
         return_out <= 1'b1;
      end
   end
endmodule

// ==== tb/irq_prio_checker_asserts.sv ====
`timescale 1ns/1ps
`include "irq_consts.svh"

module irq_prio_checker
   import irq_pkg::*;
(
   // Clock and reset.
   input wire logic       ref_clk_in,
   input wire logic       rst_in,
   // Register port.
   input reg_req_t        reg_req_in,
   input wire logic [7:0] rd_data_out,
   // Vectoring handshake.
   input irq_offer_t      offer_out,
   input wire logic       vector_ack_in,
   input wire logic       return_in,
   input wire logic [3:0] in_service_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_vectored;
      offer_out.req && vector_ack_in && !return_in;
   endsequence

   a_ack_service: assert property (s_vectored |=>
      !offer_out.req && in_service_out[$past(offer_out.level)])
      else $error("vectoring did not enter service");
   a_read_idle: assert property (
      !$past(reg_req_in.rd) |-> rd_data_out == 8'h00)
      else $error("read data outside its cycle");
   a_prio_unused: assert property ($past(reg_req_in.rd) &&
      ($past(reg_req_in.addr) == `ADDR_PRIO_LO ||
       $past(reg_req_in.addr) == `ADDR_PRIO_HI) |-> rd_data_out[7:6] == 2'h0)
      else $error("unused priority bits read nonzero");
   a_status_view: assert property ($past(reg_req_in.rd) &&
      $past(reg_req_in.addr) == `ADDR_IRQ_STATUS |-> rd_data_out ==
      {$past(offer_out.level), $past(offer_out.req), 1'b0,
       $past(in_service_out)})
      else $error("status read mismatch");
   a_offer_above: assert property (
      offer_out.req |-> in_service_out < (4'h1 << offer_out.level))
      else $error("offer not above running level");
   a_service_hold: assert property (
      !(vector_ack_in && offer_out.req) && !return_in
      |=> $stable(in_service_out))
      else $error("service state changed without cause");
   a_return_pops: assert property (return_in && !vector_ack_in &&
      in_service_out != 4'h0 |=> in_service_out < $past(in_service_out) &&
      $countones(in_service_out) + 1 == $countones($past(in_service_out)))
      else $error("return did not clear one level");
   a_quiet_after: assert property (
      vector_ack_in || return_in |=> !offer_out.req)
      else $error("offer not withdrawn after handshake");
endmodule

bind interrupt_priority_flags irq_prio_checker u_chk (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
   .rd_data_out(rd_data_out), .offer_out(offer_out),
   .vector_ack_in(vector_ack_in), .return_in(return_in),
   .in_service_out(in_service_out));

// ==== tb/test_interrupt_priority_flags.sv ====
`timescale 1ns/1ps
`include "irq_consts.svh"

module test_interrupt_priority_flags;
   import irq_pkg::*;
   logic clk = 0, rst = 1, pa_n = 1, ack, ret, stall = 1, hold = 1, rd_q = 0;
   logic pb_n = 1;
   reg_req_t req = '0;
   src_level_t src = '0;
   flag_event_t ev = '0;
   irq_offer_t offer;
   logic [14:0] en = '0;
   logic [7:0] rdat, bl;
   logic [3:0] insv, bs, sl [8] = '{1, 3, 5, 7, 10, 13, 11, 12};
   logic [31:0] r;
   logic [7:0] exp_q [$];
   int miscompares = 0, total_checks = 0;

   interrupt_priority_flags dut (.ref_clk_in(clk), .rst_in(rst),
      .reg_req_in(req), .rd_data_out(rdat), .ext_pin_a_request_n_in(pa_n),
      .ext_pin_b_request_n_in(pb_n), .src_level_in(src), .flag_event_in(ev),
      .slot_enable_in(en), .offer_out(offer), .vector_ack_in(ack),
      .return_in(ret), .in_service_out(insv));
   irq_core_model core (.ref_clk_in(clk), .rst_in(rst), .offer_in(offer),
      .in_service_in(insv), .stall_in(stall), .hold_in(hold),
      .vector_ack_out(ack), .return_out(ret));

   initial forever #12.5 clk = ~clk;

   task chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task bus(input logic w, input logic rd, input logic [7:0] a, d);
      @(posedge clk) req <= '{w, rd, a, d};
      @(posedge clk) req <= '0;
   endtask
   task rdx(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(0, 1, a, 8'h00);
   endtask
   task pulse(input logic [8:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= '0;
   endtask
   task conclude;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe.
   always @(posedge clk) begin
      if (rd_q) chk(rdat, exp_q.pop_front());
      rd_q <= req.rd;
   end

   initial begin
      #(25 * 6000);
      miscompares++;
      conclude();
   end

   initial begin
      r = $urandom(32'hcb09e607);
      repeat (8) @(posedge clk);
      rst <= 0;
      rdx(`ADDR_PRIO_LO, 8'h00);
      rdx(`ADDR_PRIO_HI, 8'h00);
      rdx(`ADDR_REQ_FLAGS, 8'h00);
      rdx(`ADDR_SPI_EXT, 8'h01);
      rdx(8'h00, 8'h00);
      r = $urandom;
      bus(1, 0, `ADDR_PRIO_LO, r[7:0]);
      bus(1, 0, `ADDR_PRIO_HI, r[15:8]);
      rdx(`ADDR_PRIO_LO, {2'h0, r[5:0]});
      rdx(`ADDR_PRIO_HI, {2'h0, r[13:8]});
      $display("test registers done");
      pulse(9'h1f7);
      rdx(`ADDR_REQ_FLAGS, 8'hff);
      bus(1, 0, `ADDR_REQ_FLAGS, 8'h00);
      pulse(9'h008);
      rdx(`ADDR_REQ_FLAGS, 8'h00);
      bus(1, 0, `ADDR_SPI_EXT, 8'h02);
      pulse(9'h004);
      rdx(`ADDR_REQ_FLAGS, 8'h00);
      pulse(9'h008);
      rdx(`ADDR_REQ_FLAGS, 8'h04);
      bus(1, 0, `ADDR_SPI_EXT, 8'h03);
      bus(1, 0, `ADDR_REQ_FLAGS, 8'h00);
      $display("test flags done");
      stall <= 0;
      hold <= 0;
      for (int b = 0; b < 8; b++) begin
         en <= 15'h1 << sl[b];
         pulse(9'h1 << (b > 2 ? b + 1 : b));
         repeat (10) @(posedge clk);
         rdx(`ADDR_REQ_FLAGS, (b > 0 && b < 6) ? 8'h00 : 8'h1 << b);
         bus(1, 0, `ADDR_REQ_FLAGS, 8'h00);
         en <= '0;
         repeat (4) @(posedge clk);
      end
      $display("test auto clear done");
      stall <= 1;
      hold <= 1;
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         bus(1, 0, `ADDR_PRIO_LO, r[7:0]);
         bus(1, 0, `ADDR_PRIO_HI, r[15:8]);
         en <= 15'h0344;
         src <= '1;
         bs = 4'h2;
         bl = {6'h0, r[9], r[1]};
         if ({6'h0, r[11], r[3]} > bl) begin
            bs = 4'h6;
            bl = {6'h0, r[11], r[3]};
         end
         if ({6'h0, r[12], r[4]} > bl) begin
            bs = 4'h8;
            bl = {6'h0, r[12], r[4]};
         end
         repeat (3) @(posedge clk);
         chk({1'b0, offer}, {2'h1, bs, bl[1:0]});
         src <= '0;
         en <= '0;
         @(posedge clk);
      end
      en <= 15'h0010;
      pb_n <= 0;
      repeat (7) @(posedge clk);
      chk({1'b0, offer}, {2'h1, 4'h4, r[10], r[2]});
      pb_n <= 1;
      en <= '0;
      repeat (5) @(posedge clk);
      $display("test arbitration done");
      bus(1, 0, `ADDR_PRIO_LO, 8'h03);
      bus(1, 0, `ADDR_PRIO_HI, 8'h19);
      stall <= 0;
      en <= 15'h0145;
      src.tmr0 <= 1;
      repeat (8) @(posedge clk);
      src.tmr1 <= 1;
      repeat (8) @(posedge clk);
      src.ser_rx <= 1;
      repeat (8) @(posedge clk);
      chk({4'h0, insv}, 8'h06);
      rdx(`ADDR_IRQ_STATUS, {2'h0, 2'h0, 4'h6});
      pa_n <= 0;
      repeat (10) @(posedge clk);
      chk({4'h0, insv}, 8'h0e);
      hold <= 0;
      pa_n <= 1;
      src <= '0;
      repeat (30) @(posedge clk);
      chk({4'h0, insv}, 8'h00);
      $display("test preemption done");
      conclude();
   end
endmodule
